// ===== verilog/clock_ctrl_consts.svh
// Offsets, field positions, reset values and timing counts of the clock control.
`ifndef CLOCK_CTRL_CONSTS_SVH
`define CLOCK_CTRL_CONSTS_SVH

// ============================================================
// Register offsets (byte addresses)
`define PLL_CFG_ADDR     12'h000
`define PLL_STATUS_ADDR  12'h004
`define CLKBLK_CFG_ADDR  12'h008
`define PORT_SEL_ADDR    12'h00C
`define TIMER_ADDR       12'h010

// ============================================================
// Field positions of the PLL configuration register
`define REF_DIV_LSB      0
`define FEEDBACK_LSB     8
`define OUT_DIV_LSB      20

// ============================================================
// Strap presets
`define STRAP00_OUT_DIV  3'h1
`define STRAP00_FEEDBACK 12'h07A
`define STRAP11_OUT_DIV  3'h2
`define STRAP11_FEEDBACK 12'h077
`define STRAP10_OUT_DIV  3'h2
`define STRAP10_FEEDBACK 12'h031
`define STRAP01_OUT_DIV  3'h2
`define STRAP01_FEEDBACK 12'h017
`define STRAP_REF_DIV    6'h00

// ============================================================
// Timing
`define STRAP_SAMPLE_EDGE 2'h3
`define LOCK_TIME_NS     20000
`define PCLK_NS          40
`define LOCK_CYCLES      ((`LOCK_TIME_NS + `PCLK_NS - 1) / `PCLK_NS)

`endif

// ===== verilog/clock_ctrl_pkg.sv
// Types shared by the clock control modules.
package clock_ctrl_pkg;

  typedef struct packed {
    logic [2:0]  output_divider;
    logic [11:0] feedback;
    logic [5:0]  ref_divider;
  } pll_cfg_s;

  typedef enum logic [1:0] {
    PLL_LOADING = 2'b00,
    PLL_LOCKING = 2'b01,
    PLL_RUNNING = 2'b10
  } pll_state_e;

  typedef struct packed {
    logic       use_ext;
    logic       drive_pin;
    logic [7:0] divide;
  } clkblk_cfg_s;

endpackage : clock_ctrl_pkg

// ===== verilog/tick_divider.sv
// Programmable enable divider producing one-cycle tick pulses.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
  parameter int WIDTH = 12
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             enable,
  input  wire logic [WIDTH-1:0] divide,
  output var  logic             tick
);
  logic [WIDTH-1:0] count;
  wire              wrap = (count >= divide);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (!enable) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= wrap ? '0 : count + 1'b1;
      tick  <= wrap;
    end
  end
endmodule : tick_divider
`default_nettype wire

// ===== verilog/clock_block.sv
// One clock block: source select, division and pin drive.
`timescale 1ns/1ps
`default_nettype none
module clock_block
  import clock_ctrl_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ref_tick,
  input  wire logic        ext_clk_pin,
  input  wire clkblk_cfg_s cfg,
  output var  logic        edge_tick,
  output var  logic        clk_out,
  output var  logic        clk_out_oe
);
  logic ext_meta;
  logic ext_sync;
  logic ext_last;
  logic [7:0] div_count;

  // The pin is asynchronous, so it is synchronised before edge detection.
  wire ext_rise = ext_sync & ~ext_last;
  wire src_tick = cfg.use_ext ? ext_rise : ref_tick;
  wire div_wrap = (div_count >= cfg.divide);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_last <= 1'b0;
    end else begin
      ext_meta <= ext_clk_pin;
      ext_sync <= ext_meta;
      ext_last <= ext_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count  <= 8'h00;
      edge_tick  <= 1'b0;
      clk_out    <= 1'b0;
      clk_out_oe <= 1'b0;
    end else begin
      edge_tick  <= src_tick & div_wrap;
      clk_out_oe <= cfg.drive_pin;
      if (src_tick) begin
        div_count <= div_wrap ? 8'h00 : div_count + 8'h01;
        if (div_wrap) begin
          clk_out <= ~clk_out;
        end
      end
    end
  end
endmodule : clock_block
`default_nettype wire

// ===== verilog/pll_strap_clock_control.sv
// Top of the clock control: straps, PLL settings, derived ticks and a timer.
//
// Function
// - One PLL clock feeds switch, tile and reference clock enables.
// - Straps set the first multiplier; software may change it later.
// - Straps 00 load output divider 1, feedback 122, reference 0.
// - Straps 10 load output divider 2, feedback 49, reference 0.
// - Straps 01 load output divider 2, feedback 23, reference 0.
// - Core rate is osc*(F+1)/2/(R+1)/(OD+1).
// - Software writes new divider values to the PLL configuration.
// - Each timer is a 32-bit counter on the reference tick.
// - Reference defaults to 100 MHz, a timer tick of 10 ns; here the reference is pclk/4, a 160 ns tick.
// - Clock blocks run from a pin or divided reference; may drive out.
// - After reset all ports use clock block 0 on the reference.
// - Boot speed follows the strap pins on leaving reset.
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "clock_ctrl_consts.svh"
module pll_strap_clock_control
  import clock_ctrl_pkg::*;
#(
  parameter int NUM_CLKBLK  = 2,
  parameter int LOCK_CYCLES = `LOCK_CYCLES,
  parameter int REF_DIV     = 4,
  parameter int SWITCH_DIV  = 2
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output var  logic [31:0]           prdata,
  output var  logic                  pready,
  output var  logic                  pslverr,
  input  wire logic                  strap_pin_low,
  input  wire logic                  strap_pin_high,
  input  wire logic [NUM_CLKBLK-1:0] ext_clk_pin,
  output var  pll_cfg_s              pll_cfg,
  output var  logic                  pll_locked,
  output var  logic                  tile_tick,
  output var  logic                  switch_tick,
  output var  logic                  ref_tick,
  output var  logic [NUM_CLKBLK-1:0] clkblk_tick,
  output var  logic [NUM_CLKBLK-1:0] clkblk_out,
  output var  logic [NUM_CLKBLK-1:0] clkblk_out_oe,
  output var  logic                  port_clkblk
);
  import clock_ctrl_pkg::*;

  // ============================================================
  // Strap capture
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;
  logic [1:0] edge_count;
  logic       strap_taken;
  pll_state_e state;
  pll_cfg_s   active_cfg;
  pll_cfg_s   pending_cfg;
  logic       pending;
  logic [31:0] lock_count;

  wire [1:0] strap_now = {strap_pin_high, strap_pin_low};
  wire       strap_edge = !strap_taken && (edge_count == `STRAP_SAMPLE_EDGE);

  pll_cfg_s strap_cfg;
  always_comb begin
    strap_cfg.ref_divider = `STRAP_REF_DIV;
    case (strap_sync)
      2'b00: begin
        strap_cfg.output_divider = `STRAP00_OUT_DIV;
        strap_cfg.feedback       = `STRAP00_FEEDBACK;
      end
      2'b11: begin
        strap_cfg.output_divider = `STRAP11_OUT_DIV;
        strap_cfg.feedback       = `STRAP11_FEEDBACK;
      end
      2'b10: begin
        strap_cfg.output_divider = `STRAP10_OUT_DIV;
        strap_cfg.feedback       = `STRAP10_FEEDBACK;
      end
      default: begin
        strap_cfg.output_divider = `STRAP01_OUT_DIV;
        strap_cfg.feedback       = `STRAP01_FEEDBACK;
      end
    endcase
  end

  // Sample straps at the third edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_meta  <= 2'b00;
      strap_sync  <= 2'b00;
      edge_count  <= 2'b00;
      strap_taken <= 1'b0;
    end else begin
      strap_meta <= strap_now;
      strap_sync <= strap_meta;
      if (!strap_taken && edge_count != `STRAP_SAMPLE_EDGE) begin
        edge_count <= edge_count + 2'b01;
      end
      if (strap_edge) begin
        strap_taken <= 1'b1;
      end
    end
  end

  // ============================================================
  // Register bus
  wire        wr_en   = psel && penable && pwrite;
  wire        rd_en   = psel && penable && !pwrite;
  wire        hit_cfg = (paddr == `PLL_CFG_ADDR);
  wire        hit_sts = (paddr == `PLL_STATUS_ADDR);
  wire        hit_cb  = (paddr == `CLKBLK_CFG_ADDR);
  wire        hit_ps  = (paddr == `PORT_SEL_ADDR);
  wire        hit_tmr = (paddr == `TIMER_ADDR);
  wire        hit_any = hit_cfg | hit_sts | hit_cb | hit_ps | hit_tmr;
  wire        cfg_wr  = wr_en && hit_cfg;
  clkblk_cfg_s cb_cfg [NUM_CLKBLK];
  logic [31:0] timer;
  logic [NUM_CLKBLK-1:0] cb_use_ext;
  logic [NUM_CLKBLK-1:0] cb_drive;
  logic [7:0]  cb_divide;
  logic        port_sel;

  wire [31:0] cfg_word = {9'h000, active_cfg.output_divider,
                          active_cfg.feedback, 2'b00,
                          active_cfg.ref_divider};
  wire [31:0] sts_word = {29'h0000_0000, pending, strap_sync == 2'b11,
                          pll_locked};
  wire [31:0] cb_word  = {8'h00, cb_divide,
                          {(8 - NUM_CLKBLK){1'b0}}, cb_drive,
                          {(8 - NUM_CLKBLK){1'b0}}, cb_use_ext};
  wire [31:0] rd_word  = hit_cfg ? cfg_word :
                         hit_sts ? sts_word :
                         hit_cb  ? cb_word  :
                         hit_ps  ? {31'h0000_0000, port_sel} :
                         hit_tmr ? timer : 32'h0000_0000;

  // Clock block 0 on reference, ports on block 0.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_use_ext <= '0;
      cb_drive   <= '0;
      cb_divide  <= 8'h00;
      port_sel   <= 1'b0;
    end else if (wr_en && hit_cb) begin
      cb_use_ext <= pwdata[NUM_CLKBLK-1:0];
      cb_drive   <= pwdata[8 +: NUM_CLKBLK];
      cb_divide  <= pwdata[23:16];
    end else if (wr_en && hit_ps) begin
      port_sel <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata  <= (psel && !penable && !pwrite) ? rd_word : prdata;
    end
  end

  // ============================================================
  // PLL control
  // New divider values are held until the PLL is running, then applied with a relock.
  // Ticks stop while locking so no short pulse escapes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= PLL_LOADING;
      active_cfg  <= '0;
      pending_cfg <= '0;
      pending     <= 1'b0;
      lock_count  <= 32'h0000_0000;
      pll_locked  <= 1'b0;
      pll_cfg     <= '0;
    end else begin
      if (cfg_wr && pready) begin
        pending_cfg <= '{pwdata[`OUT_DIV_LSB +: 3],
                         pwdata[`FEEDBACK_LSB +: 12],
                         pwdata[`REF_DIV_LSB +: 6]};
        pending     <= 1'b1;
      end
      case (state)
        // First settings come from the straps.
        PLL_LOADING: begin
          if (strap_edge) begin
            active_cfg <= strap_cfg;
            pll_cfg    <= strap_cfg;
            lock_count <= 32'h0000_0000;
            state      <= PLL_LOCKING;
          end
        end
        PLL_LOCKING: begin
          pll_locked <= 1'b0;
          if (lock_count >= 32'(LOCK_CYCLES - 1)) begin
            state      <= PLL_RUNNING;
            pll_locked <= 1'b1;
          end else begin
            lock_count <= lock_count + 32'h0000_0001;
          end
        end
        PLL_RUNNING: begin
          if (pending && !(cfg_wr && pready)) begin
            active_cfg <= pending_cfg;
            pll_cfg    <= pending_cfg;
            pending    <= 1'b0;
            pll_locked <= 1'b0;
            lock_count <= 32'h0000_0000;
            state      <= PLL_LOCKING;
          end
        end
        default: state <= PLL_LOADING;
      endcase
    end
  end

  // ============================================================
  // Derived clock enables
  // Tile, switch and reference from one PLL enable.
  logic ref_pulse;
  logic sw_pulse;
  tick_divider #(.WIDTH(8)) u_switch (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (pll_locked),
    .divide  (8'(SWITCH_DIV - 1)),
    .tick    (sw_pulse)
  );
  // Reference divider sets the default rate of one tick every 4 pclk cycles (160 ns).
  tick_divider #(.WIDTH(8)) u_ref (
    .pclk    (pclk),
    .presetn (presetn),
    .enable  (pll_locked),
    .divide  (8'(REF_DIV - 1)),
    .tick    (ref_pulse)
  );

  // Gate by lock.
  // A divider may still emit one pulse on the edge that drops the lock.
  wire ref_live = ref_pulse & pll_locked;
  wire sw_live  = sw_pulse & pll_locked;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tile_tick   <= 1'b0;
      switch_tick <= 1'b0;
      ref_tick    <= 1'b0;
      port_clkblk <= 1'b0;
    end else begin
      tile_tick   <= pll_locked;
      switch_tick <= sw_live;
      ref_tick    <= ref_live;
      port_clkblk <= port_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer <= 32'h0000_0000;
    end else if (ref_live) begin
      timer <= timer + 32'h0000_0001;
    end
  end

  for (genvar i = 0; i < NUM_CLKBLK; i++) begin : g_cb
    assign cb_cfg[i] = '{cb_use_ext[i], cb_drive[i], cb_divide};
    clock_block u_cb (
      .pclk        (pclk),
      .presetn     (presetn),
      .ref_tick    (ref_live),
      .ext_clk_pin (ext_clk_pin[i]),
      .cfg         (cb_cfg[i]),
      .edge_tick   (clkblk_tick[i]),
      .clk_out     (clkblk_out[i]),
      .clk_out_oe  (clkblk_out_oe[i])
    );
  end
endmodule : pll_strap_clock_control
`default_nettype wire

// ===== verification/clock_ctrl_assertions.sv
// Port checker for the PLL strap clock control.
`timescale 1ns/1ps
`default_nettype none
module clock_ctrl_checker
  import clock_ctrl_pkg::*;
#(
  parameter int NUM_CLKBLK = 2,
  parameter int REF_DIV    = 4
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire pll_cfg_s              pll_cfg,
  input wire logic                  pll_locked,
  input wire logic                  tile_tick,
  input wire logic                  switch_tick,
  input wire logic                  ref_tick,
  input wire logic [NUM_CLKBLK-1:0] clkblk_out_oe,
  input wire logic                  port_clkblk
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ============================================================
  // Spacing of reference ticks, counted only across a steady lock.
  int   gap;
  logic seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap  <= 0;
      seen <= 1'b0;
    end else begin
      gap  <= ref_tick ? 0 : gap + 1;
      seen <= pll_locked && (seen || ref_tick);
    end
  end
  a_ref_period:
    assert property (ref_tick && seen |-> gap == REF_DIV - 1)
    else $error("reference tick spacing wrong");
  a_tile_lock:
    assert property (tile_tick == $past(pll_locked))
    else $error("tile enable differs from lock");
  a_unlocked_quiet:
    assert property (!pll_locked && !$past(pll_locked)
                     |-> !ref_tick && !switch_tick)
    else $error("tick while unlocked");
  a_cfg_hold:
    assert property (pll_locked |-> $stable(pll_cfg))
    else $error("settings changed while locked");
  a_apb_answer:
    assert property (psel && !penable |=> pready)
    else $error("no answer in access phase");
  a_ready_once:
    assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready:
    assert property (pslverr |-> pready && psel && penable)
    else $error("error outside access phase");
  a_port_reset:
    assert property ($rose(presetn) |-> !port_clkblk && clkblk_out_oe == '0)
    else $error("port clocking not at block 0");
  c_ref: cover property (ref_tick && seen);
  c_err: cover property (pslverr);
  c_relock: cover property ($fell(pll_locked));
  c_drive: cover property (clkblk_out_oe[0]);
endmodule : clock_ctrl_checker
bind pll_strap_clock_control clock_ctrl_checker #(
  .NUM_CLKBLK(NUM_CLKBLK), .REF_DIV(REF_DIV)
) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .pll_cfg(pll_cfg),
  .pll_locked(pll_locked), .tile_tick(tile_tick),
  .switch_tick(switch_tick), .ref_tick(ref_tick),
  .clkblk_out_oe(clkblk_out_oe), .port_clkblk(port_clkblk)
);
`default_nettype wire

// ===== verification/board_model.sv
// Board model: strap pins and external clock pins.
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] strap_code,
  output var  logic       strap_pin_low,
  output var  logic       strap_pin_high,
  output var  logic [1:0] ext_clk_pin
);
  // ============================================================
  // Straps and clocks
  int   edges = 0;
  logic osc   = 1'b0;
  always #70 osc = ~osc;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) edges <= 0;
    else if (edges < 3) edges <= edges + 1;
  end
  // Hold until third edge.
  // The pins flip afterwards, so a late sample loads a wrong preset.
  assign {strap_pin_high, strap_pin_low} =
    (edges < 3) ? strap_code : ~strap_code;
  assign ext_clk_pin = {~osc, osc};
endmodule : board_model
`default_nettype wire

// ===== verification/pll_strap_clock_control_tb.sv
// Testbench for the PLL strap clock control.
`timescale 1ns/1ps
`default_nettype none
module pll_strap_clock_control_tb;
  import clock_ctrl_pkg::*;
  // ============================================================
  // Signals
  localparam int REF_DIV = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0]  strap_code = 2'b00;
  logic [31:0] prdata, rdv;
  logic        pready, pslverr, errv, pll_locked, tile_tick;
  logic        switch_tick, ref_tick, port_clkblk;
  logic        strap_pin_low, strap_pin_high;
  logic [1:0]  ext_clk_pin, clkblk_tick, clkblk_out, clkblk_out_oe;
  pll_cfg_s    pll_cfg;
  logic [20:0] preset_cfg [4] = '{{3'h1, 12'd122, 6'h00},
    {3'h2, 12'd23, 6'h00}, {3'h2, 12'd49, 6'h00}, {3'h2, 12'd119, 6'h00}};
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles = 0;
  always #20 pclk = ~pclk;
  board_model u_board (.pclk(pclk), .presetn(presetn),
    .strap_code(strap_code), .strap_pin_low(strap_pin_low),
    .strap_pin_high(strap_pin_high), .ext_clk_pin(ext_clk_pin));
  // A short lock keeps each relock within a few cycles.
  pll_strap_clock_control #(.NUM_CLKBLK(2), .LOCK_CYCLES(4),
    .REF_DIV(REF_DIV), .SWITCH_DIV(2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .strap_pin_low(strap_pin_low),
    .strap_pin_high(strap_pin_high), .ext_clk_pin(ext_clk_pin),
    .pll_cfg(pll_cfg), .pll_locked(pll_locked), .tile_tick(tile_tick),
    .switch_tick(switch_tick), .ref_tick(ref_tick),
    .clkblk_tick(clkblk_tick), .clkblk_out(clkblk_out),
    .clkblk_out_oe(clkblk_out_oe), .port_clkblk(port_clkblk));
  // ============================================================
  // Helpers
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wait_sig(input int sel, input logic lvl);
    int n;
    n = 0;
    while ((sel ? clkblk_tick[0] : pll_locked) !== lvl && n < 300) begin
      @(posedge pclk);
      n++;
    end
  endtask : wait_sig
  function logic [31:0] pll_word(input logic [20:0] e);
    return {9'h000, e[20:18], e[17:6], 2'b00, e[5:0]};
  endfunction : pll_word
  // ============================================================
  // Scenarios
  task test_straps;
    for (int c = 0; c < 4; c++) begin
      @(posedge pclk);
      presetn <= 1'b0;
      strap_code <= c[1:0];
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("port_clkblk", 32'h0, {31'h0, port_clkblk});
      wait_sig(0, 1'b1);
      chk("pll_locked", 32'h1, {31'h0, pll_locked});
      chk("pll_cfg", {11'h0, preset_cfg[c]}, {11'h0, pll_cfg});
      apb(1'b0, 12'h000, 32'h0);
      chk("pll_cfg_reg", pll_word(preset_cfg[c]), rdv);
    end
  endtask : test_straps
  task test_timer;
    logic [31:0] t0;
    apb(1'b0, 12'h010, 32'h0);
    t0 = rdv;
    repeat (37) @(posedge pclk);
    apb(1'b0, 12'h010, 32'h0);
    chk("timer_delta", 40 / REF_DIV, rdv - t0);
  endtask : test_timer
  task test_clkblk;
    apb(1'b0, 12'h00C, 32'h0);
    chk("port_sel_reg", 32'h0, rdv);
    apb(1'b0, 12'h008, 32'h0);
    chk("clkblk_reg", 32'h0, rdv);
    wait_sig(1, 1'b1);
    chk("ref_tick0", 32'h1, {31'h0, clkblk_tick[0]});
    apb(1'b1, 12'h008, 32'h0000_0101);
    repeat (2) @(posedge pclk);
    chk("clkblk_oe", 32'h1, {30'h0, clkblk_out_oe});
    wait_sig(1, 1'b1);
    chk("ext_tick0", 32'h1, {31'h0, clkblk_tick[0]});
    apb(1'b1, 12'h00C, 32'h0000_0001);
    repeat (2) @(posedge pclk);
    chk("port_clkblk", 32'h1, {31'h0, port_clkblk});
  endtask : test_clkblk
  task test_pll_write;
    apb(1'b1, 12'h000, 32'h0030_3101);
    wait_sig(0, 1'b0);
    chk("pll_unlock", 32'h0, {31'h0, pll_locked});
    wait_sig(0, 1'b1);
    chk("pll_cfg", {11'h0, 3'h3, 12'h031, 6'h01}, {11'h0, pll_cfg});
    apb(1'b0, 12'h000, 32'h0);
    chk("pll_cfg_reg", 32'h0030_3101, rdv);
  endtask : test_pll_write
  task test_unmapped;
    apb(1'b0, 12'h040, 32'h0);
    chk("pslverr", 32'h1, {31'h0, errv});
    apb(1'b0, 12'h004, 32'h0);
    chk("status_locked", 32'h1, {31'h0, rdv[0]});
  endtask : test_unmapped
  // ============================================================
  // Run control
  task summarize;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    test_straps();
    test_timer();
    test_clkblk();
    test_pll_write();
    test_unmapped();
    summarize();
  end
endmodule : pll_strap_clock_control_tb
`default_nettype wire
